// File: adc_queue_seq.v
// Queue sequencer: two prioritised queues over a 64-entry command table.
// Assumes an AXI4-Lite master on clk_sys; trigger pins are asynchronous.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adc_queue_map.vh"
module adc_queue_seq (
    input wire clk_sys,
    input wire resetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire trig1_pin,
    input wire trig2_pin,
    input wire timer_expired,
    output reg conv_start,
    output reg [5:0] conv_channel,
    output reg table_wait
);
// ****************************************************************
// state
// ****************************************************************
localparam S_IDLE = 2'd0;
localparam S_FETCH = 2'd1;
localparam S_CONV = 2'd2;
localparam S_PAUSE = 2'd3;

reg [7:0] ccw_mem [0:63];
reg [2:0] mode_q [0:1];
reg [1:0] arm_q;
reg [1:0] cf_q;
reg [1:0] pf_q;
reg [1:0] tor_q;
reg [1:0] pend_q;
reg [6:0] start_ptr_q;
reg [1:0] st_q;
reg cur_q;
reg [6:0] ptr_q;
reg [7:0] ccw_q;
reg [7:0] cnt_q;
reg [1:0] sync0_q;
reg [1:0] sync1_q;
reg [1:0] sync2_q;
reg [1:0] tmr_q;
reg aw_hold_q;
reg w_hold_q;
reg [3:0] awaddr_q;
reg [31:0] wdata_q;

wire [1:0] trig_ev;
wire [1:0] edge_trig;
wire do_write;
wire [1:0] mode_wr;
wire [1:0] arm_wr;
wire [1:0] sw_fire;
wire [1:0] active;
wire [1:0] q_busy;
wire [6:0] q_end;
wire [6:0] q_base;
wire pause_word;
wire eoq_here;
wire stat_clr;
wire [7:0] next_ccw;

// ****************************************************************
// trigger qualification
// ****************************************************************
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        sync0_q <= 2'h0;
        sync1_q <= 2'h0;
        sync2_q <= 2'h0;
        tmr_q <= 2'h0;
    end else begin
        sync0_q <= {trig2_pin, trig1_pin};
        sync1_q <= sync0_q; // RL24
        sync2_q <= sync1_q;
        tmr_q <= {tmr_q[0], timer_expired};
    end
end

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_q
        // one event per qualifying edge, timer counted on its rising edge
        assign edge_trig[gi] = (mode_q[gi] == `MODE_EXT_RISE) ? (sync1_q[gi] & ~sync2_q[gi]) :
                               (mode_q[gi] == `MODE_EXT_FALL) ? (~sync1_q[gi] & sync2_q[gi]) :
                               (mode_q[gi] == `MODE_TIMER) ? (tmr_q[0] & ~tmr_q[1]) : // RL19
                               1'b0; // RL21
        // disabled and reserved codes never qualify
        assign active[gi] = (mode_q[gi] == `MODE_SOFTWARE) || (mode_q[gi] == `MODE_EXT_RISE) ||
                            (mode_q[gi] == `MODE_EXT_FALL) || (mode_q[gi] == `MODE_TIMER) ||
                            (gi == 0 && mode_q[gi] == `MODE_GATED); // RL8 RL9 RL10
        assign trig_ev[gi] = active[gi] & arm_q[gi] & edge_trig[gi]; // RL11
        assign q_busy[gi] = (st_q != S_IDLE) && (cur_q == gi);
        assign mode_wr[gi] = do_write && awaddr_q == (gi ? `OFS_CTRL2 : `OFS_CTRL1) &&
                             wdata_q[2:0] != mode_q[gi];
        assign arm_wr[gi] = do_write && awaddr_q == (gi ? `OFS_CTRL2 : `OFS_CTRL1) &&
                            wdata_q[`ARM_BIT];
        assign sw_fire[gi] = arm_wr[gi] && !arm_q[gi] &&
                             wdata_q[2:0] == `MODE_SOFTWARE; // RL16
    end
endgenerate

assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
assign q_base = cur_q ? start_ptr_q : 7'h00;
assign q_end = cur_q ? 7'h40 : start_ptr_q;
assign pause_word = ccw_q[`CCW_PAUSE_BIT];
assign eoq_here = (ccw_q[5:0] == `EOQ_CHANNEL) || (ptr_q >= q_end) || (ptr_q >= 7'h40);
assign stat_clr = do_write && (awaddr_q == `OFS_STATUS);
// look ahead at the word after a pause so an end code there never leaves us paused
assign next_ccw = ccw_mem[ptr_q[5:0]];

// ****************************************************************
// sequencer
// ****************************************************************
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        st_q <= S_IDLE;
        cur_q <= 1'b0;
        ptr_q <= 7'h00;
        ccw_q <= 8'h00;
        cnt_q <= 8'h00;
        arm_q <= 2'h0;
        cf_q <= 2'h0;
        pf_q <= 2'h0;
        tor_q <= 2'h0;
        pend_q <= 2'h0;
        conv_start <= 1'b0;
        conv_channel <= 6'h00;
        table_wait <= 1'b0;
    end else begin
        conv_start <= 1'b0;
        table_wait <= active[0] | active[1]; // RL8
        // software arm: set only, device clears on completion
        arm_q <= arm_q | {arm_wr[1], arm_wr[0]}; // RL12
        // overrun on premature edge or timer trigger, never software
        // a set in the same cycle as a clear wins, so no overrun is lost
        tor_q <= (tor_q & ~(stat_clr ? wdata_q[5:4] : 2'h0)) |
                 (trig_ev & (q_busy | pend_q) & ~{st_q == S_PAUSE, st_q == S_PAUSE}); // RL17 RL18 RL23
        pend_q <= pend_q | (trig_ev & ~q_busy) | sw_fire;
        if (stat_clr) begin
            cf_q <= cf_q & ~wdata_q[1:0];
            pf_q <= pf_q & ~wdata_q[3:2];
        end
        if ((mode_wr[0] && cur_q == 1'b0 || mode_wr[1] && cur_q == 1'b1) && st_q != S_IDLE) begin
            st_q <= S_IDLE; // RL14
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (pend_q[0] || pend_q[1]) begin
                        cur_q <= ~pend_q[0];
                        ptr_q <= pend_q[0] ? 7'h00 : start_ptr_q; // RL15 RL20
                        pend_q[pend_q[0] ? 0 : 1] <= 1'b0;
                        st_q <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    ccw_q <= (ptr_q < 7'h40) ? ccw_mem[ptr_q[5:0]] : 8'h3F; // RL4
                    st_q <= S_CONV;
                    cnt_q <= 8'h00;
                end
                S_CONV: begin
                    if (cnt_q == 8'h00 && eoq_here) begin
                        // end wins over pause; several ends fold into one
                        cf_q[cur_q] <= 1'b1; // RL1 RL3 RL6 RL7
                        arm_q[cur_q] <= 1'b0; // RL13
                        st_q <= S_IDLE;
                    end else if (cnt_q == 8'h00) begin
                        conv_start <= 1'b1;
                        conv_channel <= ccw_q[5:0];
                        cnt_q <= 8'h01;
                    end else if (cnt_q == `CONV_CYCLES) begin
                        ptr_q <= ptr_q + 7'h01; // RL2
                        if (pause_word) begin
                            pf_q[cur_q] <= 1'b1; // RL5
                            st_q <= S_PAUSE;
                        end else begin
                            st_q <= S_FETCH;
                        end
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                S_PAUSE: begin
                    // a pause right before the end still completes
                    if (ptr_q >= q_end || ptr_q >= 7'h40 ||
                        next_ccw[5:0] == `EOQ_CHANNEL) begin
                        cf_q[cur_q] <= 1'b1; // RL5
                        arm_q[cur_q] <= 1'b0;
                        st_q <= S_IDLE;
                    end else if (mode_q[cur_q] == `MODE_SOFTWARE || mode_q[cur_q] == `MODE_GATED ||
                                 trig_ev[cur_q]) begin
                        st_q <= S_FETCH; // RL16 RL22
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
end

// ****************************************************************
// register bus
// ****************************************************************
integer k;
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        mode_q[0] <= `MODE_DISABLED;
        mode_q[1] <= `MODE_DISABLED;
        start_ptr_q <= `START_PTR_RESET;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        awaddr_q <= 4'h0;
        wdata_q <= 32'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h0;
        for (k = 0; k < 64; k = k + 1) begin
            ccw_mem[k] <= 8'h3F;
        end
    end else begin
        s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
        s_axi_wready <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
        end
        if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
            if (awaddr_q == `OFS_CTRL1)
                mode_q[0] <= wdata_q[2:0]; // RL10 RL14
            if (awaddr_q == `OFS_CTRL2)
                mode_q[1] <= wdata_q[2:0];
            if (awaddr_q == `OFS_TABLE_PTR) begin
                // bit 31 selects a table write, otherwise the queue-2 start
                if (wdata_q[31])
                    ccw_mem[wdata_q[21:16]] <= wdata_q[7:0];
                else
                    start_ptr_q <= wdata_q[6:0];
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
        end
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `OFS_CTRL1: s_axi_rdata <= {29'h0, mode_q[0]}; // RL12
                `OFS_CTRL2: s_axi_rdata <= {29'h0, mode_q[1]};
                `OFS_STATUS: s_axi_rdata <= {20'h0, st_q, cur_q, 1'b0, arm_q, tor_q, pf_q, cf_q};
                `OFS_TABLE_PTR: s_axi_rdata <= {25'h0, start_ptr_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end
endmodule // adc_queue_seq

// File: adc_queue_map.vh
// Constants for the queue sequencer: register offsets, fields, modes, codes.
// Assumes a 32-bit AXI4-Lite master and byte addresses aligned to words.
// Behaviour
// RL1 - first command word holding end-of-queue code: read it, flag complete, idle, no conversion
// RL2 - queue 2 starting at last entry: convert it, then complete and idle
// RL3 - queue 1 reaching a queue-2 start of zero: read entry zero, complete, idle
// RL4 - queue 2 start beyond table: complete at once and idle, no conversion
// RL5 - pause word followed by end of queue: convert, set pause and completion, idle
// RL6 - pause and end of queue in one word: no conversion, no pause, completion set
// RL7 - several end-of-queue conditions on one word act like a single one
// RL8 - disabled queue ignores triggers; both disabled means no table wait states
// RL9 - reserved mode behaves exactly like disabled mode
// RL10 - mode field picks software, external, gated or timer single scan; gated queue 1 only; the code never starts a gated scan
// RL11 - single-scan triggers ignored until the queue's arm bit is set
// RL12 - arm bit set by writing one only, reads zero, cleared only by device
// RL13 - arm bit stays set until completion, then device clears it
// RL14 - mode change while running aborts conversion and applies new mode and arm
// RL15 - armed trigger starts execution at the queue's first command word
// RL16 - software mode: arming triggers internally; pauses re-trigger internally until end
// RL17 - edge and timer modes: trigger during execution sets overrun flag
// RL18 - overrun never set in software mode; status may briefly show paused
// RL19 - timer mode: next interval timer expiry is the trigger
// RL20 - after completion status is idle; re-arm restarts from first word
// RL21 - rising and falling external edges; first edge after arm runs once
// RL22 - external mode pause waits for another edge, resumes without software
// RL23 - premature trigger only sets overrun and does not disturb execution
// RL24 - external triggers synchronised, each selected edge gives one event
`ifndef ADC_QUEUE_MAP_VH
`define ADC_QUEUE_MAP_VH
`define OFS_CTRL1 4'h0
`define OFS_CTRL2 4'h4
`define OFS_STATUS 4'h8
`define OFS_TABLE_PTR 4'hC
`define MODE_DISABLED 3'h0
`define MODE_SOFTWARE 3'h1
`define MODE_EXT_RISE 3'h2
`define MODE_EXT_FALL 3'h3
`define MODE_GATED 3'h4
`define MODE_TIMER 3'h5
`define EOQ_CHANNEL 6'h3F
`define CCW_PAUSE_BIT 6
`define ARM_BIT 8
`define START_PTR_RESET 7'h20
`define CONV_TIME_NS 1000
`define CLK_NS 10
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: adc_queue_seq_sva.sv
// Checker for the sequencer's bus handshakes and conversion starts.
// Assumes it is bound to adc_queue_seq and sees only that module's ports.
`timescale 1ns/1ps
module adc_queue_seq_chk (
    input wire clk_sys,
    input wire resetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire conv_start,
    input wire [5:0] conv_channel,
    input wire table_wait
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    no_eoq_conv_a: assert property (conv_start |-> conv_channel != 6'h3F)
        else $error("end code channel was converted");
    // no second conversion start in the eight cycles after a start
    one_start_a: assert property (conv_start |=> !conv_start [*8])
        else $error("conversion restarted too soon");
    busy_conv_a: assert property (conv_start |-> table_wait ##1 table_wait [*8])
        else $error("table wait low during conversion");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    b_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    r_late_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
        else $error("illegal read response");
    b_late_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
endmodule // adc_queue_seq_chk
bind adc_queue_seq adc_queue_seq_chk chk_u (.clk_sys, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start,
    .conv_channel, .table_wait);

// File: trig_src.sv
// Far-side stand-in: external trigger pins and the interval timer expiry.
// Assumes the bench calls fire() from its own sequence, one call at a time.
`timescale 1ns/1ps
module trig_src (
    input wire clk_sys,
    output reg trig1_pin,
    output reg trig2_pin,
    output reg timer_expired
);
    // ****************************************
    // event source
    // ****************************************
    initial begin
        trig1_pin = 1'b0;
        trig2_pin = 1'b0;
        timer_expired = 1'b0;
    end
    // four cycles each way so the two-flop synchroniser cannot miss a level
    task fire(input [2:0] sel);
        begin
            @(posedge clk_sys);
            {timer_expired, trig2_pin, trig1_pin} <= sel;
            repeat (4) @(posedge clk_sys);
            {timer_expired, trig2_pin, trig1_pin} <= 3'h0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
endmodule // trig_src

// File: adc_queue_seq_test.sv
// Self-checking bench: register bus, table walks, triggers and flags.
// Assumes trig_src and the bound checker are compiled alongside.
`timescale 1ns/1ps
module adc_queue_seq_test;
    // ****************************************
    // bench
    // ****************************************
    reg clk_sys, resetn, awv, wv, brdy, arv, rrdy;
    reg [3:0] awa, ara, ws;
    reg [31:0] wd, st;
    reg [5:0] lastch;
    wire awr, wr_r, bv, arr, rv, cs, tw, t1, t2, tx;
    wire [1:0] br, rr;
    wire [31:0] rdata;
    wire [5:0] ch;
    integer miscompares, checks, nconv, n0;
    adc_queue_seq dut_u (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .trig1_pin(t1), .trig2_pin(t2), .timer_expired(tx), .conv_start(cs),
        .conv_channel(ch), .table_wait(tw));
    trig_src trig_u (.clk_sys(clk_sys), .trig1_pin(t1), .trig2_pin(t2), .timer_expired(tx));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (cs === 1'b1) begin
            nconv <= nconv + 1;
            lastch <= ch;
        end
    end
    task chk(input [127:0] what, input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected %0s: expected %h, seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            {awa, wd, ws, awv, wv, brdy} <= {a, d, 4'hF, 3'h7};
            while (!(bv && brdy)) begin
                @(posedge clk_sys);
                if (awr) awv <= 1'b0;
                if (wr_r) wv <= 1'b0;
            end
            brdy <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [31:0] d);
        begin
            @(posedge clk_sys);
            {ara, arv, rrdy} <= {a, 2'h3};
            while (!(rv && rrdy)) begin
                @(posedge clk_sys);
                if (arr) arv <= 1'b0;
            end
            d = rdata;
            rrdy <= 1'b0;
        end
    endtask
    task tbl(input [5:0] i, input [7:0] v);
        wr(4'hC, {1'b1, 9'h0, i, 8'h0, v});
    endtask
    // flags are cleared first so each run is judged on its own
    task go(input [3:0] a, input [31:0] d);
        begin
            wr(4'h8, 32'h3F);
            n0 = nconv;
            wr(a, d);
        end
    endtask
    task wait_flag(input [31:0] m);
        integer k;
        begin
            st = 32'h0;
            for (k = 0; k < 300 && (st & m) == 0; k = k + 1) rd(4'h8, st);
        end
    endtask
    task expect_run(input [31:0] s, input [31:0] conv);
        begin
            rd(4'h8, st);
            chk("status", st & 32'hCFF, s);
            chk("conversions", nconv - n0, conv);
        end
    endtask
    task s_reset;
        begin
            rd(4'hC, st);
            chk("start pointer", st & 32'h7F, 32'h20);
            expect_run(32'h0, 32'h0);
        end
    endtask
    task s_eoq;
        begin
            go(4'h0, 32'h101);
            wait_flag(32'h1);
            expect_run(32'h001, 32'h0);
            rd(4'h0, st);
            chk("arm readback", st & 32'h100, 32'h0);
        end
    endtask
    task s_pause;
        begin
            tbl(6'h0, 8'h45);
            tbl(6'h1, 8'h46);
            go(4'h0, 32'h101);
            wait_flag(32'h1);
            expect_run(32'h005, 32'h2);
            chk("channel", {26'h0, lastch}, 32'h6);
        end
    endtask
    task s_same;
        begin
            tbl(6'h0, 8'h7F);
            go(4'h0, 32'h101);
            wait_flag(32'h1);
            expect_run(32'h001, 32'h0);
        end
    endtask
    task s_ext;
        begin
            tbl(6'h0, 8'h45);
            tbl(6'h1, 8'h06);
            go(4'h0, 32'h002);
            trig_u.fire(3'h1);
            expect_run(32'h0, 32'h0);
            wr(4'h0, 32'h102);
            trig_u.fire(3'h1);
            trig_u.fire(3'h1);
            repeat (150) @(posedge clk_sys);
            rd(4'h8, st);
            chk("paused state", {30'h0, st[11:10]}, 32'h3);
            trig_u.fire(3'h1);
            wait_flag(32'h1);
            expect_run(32'h015, 32'h2);
            chk("channel", {26'h0, lastch}, 32'h6);
        end
    endtask
    task s_q2;
        begin
            wr(4'hC, 32'h3F);
            tbl(6'h3F, 8'h07);
            go(4'h4, 32'h105);
            trig_u.fire(3'h4);
            wait_flag(32'h2);
            expect_run(32'h002, 32'h1);
            chk("channel", {26'h0, lastch}, 32'h7);
            wr(4'hC, 32'h40);
            go(4'h4, 32'h105);
            trig_u.fire(3'h4);
            wait_flag(32'h2);
            expect_run(32'h002, 32'h0);
            wr(4'hC, 32'h0);
            go(4'h0, 32'h101);
            wait_flag(32'h1);
            expect_run(32'h001, 32'h0);
        end
    endtask
    task s_off;
        begin
            go(4'h0, 32'h100);
            wr(4'h4, 32'h106);
            trig_u.fire(3'h7);
            chk("table wait", {31'h0, tw}, 32'h0);
            rd(4'h8, st);
            chk("status", st & 32'hC3F, 32'h0);
            chk("conversions", nconv - n0, 32'h0);
            wr(4'h4, 32'h104);
            trig_u.fire(3'h7);
            chk("gated q2 wait", {31'h0, tw}, 32'h0);
            chk("gated q2 runs", nconv - n0, 32'h0);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d miscompares %0d", checks, miscompares);
            if (miscompares == 0 && checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        {resetn, awv, wv, brdy, arv, rrdy, awa, ara, wd, ws} = 0;
        {miscompares, checks, nconv, n0} = 0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        s_reset;
        s_eoq;
        s_pause;
        s_same;
        s_ext;
        s_q2;
        s_off;
        tally_and_finish;
    end
    // the longest scenario needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares = miscompares + 1;
        tally_and_finish;
    end
endmodule // adc_queue_seq_test
